// ===== uart_lsr_defs.svh
// register offsets, field positions, reset values and sizes for the line status block
`ifndef UART_LSR_DEFS_SVH
`define UART_LSR_DEFS_SVH

// register port geometry
`define ADDR_W 3
`define DATA_W 8

// register offsets
`define REG_DATA 3'h0
`define REG_CFG 3'h3
`define REG_LINE_STATUS 3'h5

// config register fields
`define CFG_FIFO_EN 0
`define CFG_THRE_IE 1
`define CFG_WLEN_LO 2
`define CFG_WLEN_HI 3
`define CFG_PAR_EN 4
`define CFG_PAR_EVEN 5
`define CFG_PAR_STICK 6
`define CFG_RESET 8'h00

// line status fields
`define LS_FIFO_ERR 7
`define LS_TEMT 6
`define LS_THRE 5
`define LS_BREAK 4
`define LS_FRAME 3
`define LS_PARITY 2
`define LS_LOW_ZERO 2'h0

// receive entry layout: tags above the data byte
`define TAG_PAR 8
`define TAG_FRM 9
`define TAG_BRK 10
`define RX_ENTRY_W 11

// fifo sizes and capacities
`define FIFO_DEPTH 16
`define FIFO_PTR_W 4
`define FIFO_CNT_W 5
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CAP_NOFIFO 5'h01
`define CAP_FIFO 5'h10

// word length mask base
`define WLEN_MAX 2'h3
`define MASK_ALL 8'hFF

// synchroniser length and idle line level
`define SYNC_STAGES 3
`define SYNC_IDLE 3'h7

`endif

// ===== uart_lsr_pkg.sv
// shared types for the line status block
package uart_lsr_pkg;
   typedef logic [7:0] byte_t;           // one character
   typedef logic [2:0] addr_t;           // register offset
   typedef logic [4:0] count_t;          // fifo fill count
   typedef logic [10:0] rx_entry_t;      // tags plus data byte
endpackage

// ===== lsr_line_sync.sv
// three-stage synchroniser with agreement filter for the serial input line
`timescale 1ns/1ps
`include "uart_lsr_defs.svh"

module lsr_line_sync (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic async_i,
   output logic level_o
);

   logic [`SYNC_STAGES-1:0] stage_reg; // stage 0 feeds only stage 1
   wire agree = (stage_reg[1] == stage_reg[2]); // second and third match

   ////////////////////////////////////////////////////////////////////////////
   // shift chain, idle line is high
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         stage_reg <= `SYNC_IDLE;
      end else begin
         stage_reg <= {stage_reg[1:0], async_i};
      end
   end

   // filtered level, moves only on agreement
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         level_o <= 1'b1;
      end else if (agree) begin
         level_o <= stage_reg[2];
      end
   end

endmodule

// ===== lsr_char_fifo.sv
// character fifo with run-time capacity, used for both directions
`timescale 1ns/1ps
`include "uart_lsr_defs.svh"

module lsr_char_fifo #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [`FIFO_CNT_W-1:0] cap_i,
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   input wire logic pop_i,
   output logic [WIDTH-1:0] head_o,
   output logic [`FIFO_CNT_W-1:0] count_o,
   output logic full_o,
   output logic empty_o
);

   logic [WIDTH-1:0] mem [0:`FIFO_DEPTH-1]; // storage
   logic [`FIFO_PTR_W-1:0] wr_ptr_reg; // next free slot
   logic [`FIFO_PTR_W-1:0] rd_ptr_reg; // head slot
   logic [`FIFO_CNT_W-1:0] count_reg; // fill level

   wire do_push = push_i & ~full_o; // dropped when at capacity
   wire do_pop = pop_i & ~empty_o; // ignored when empty

   assign count_o = count_reg;
   assign full_o = (count_reg >= cap_i);
   assign empty_o = (count_reg == `CNT_ZERO);
   assign head_o = mem[rd_ptr_reg];

   ////////////////////////////////////////////////////////////////////////////
   // storage write, no reset needed
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[wr_ptr_reg] <= push_data_i;
      end
   end

   // pointers and count
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= `CNT_ZERO;
      end else begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + {4'h0, do_push} - {4'h0, do_pop};
      end
   end

endmodule

// ===== uart_line_status_flags.sv
// line status flags, receive tag fifo and transmit holding stage of one channel
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "uart_lsr_defs.svh"

module uart_line_status_flags (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic [`ADDR_W-1:0] addr_i,
   input wire logic [`DATA_W-1:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [`DATA_W-1:0] rd_data_o,
   input wire logic rx_char_valid_i,
   input wire logic [`DATA_W-1:0] rx_data_i,
   input wire logic rx_par_bit_i,
   input wire logic rx_stop_ok_i,
   input wire logic rx_frame_zero_i,
   input wire logic rx_line_i,
   input wire logic tx_take_i,
   input wire logic tx_shift_busy_i,
   output logic tx_valid_o,
   output logic [`DATA_W-1:0] tx_data_o,
   output logic tx_irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // parity check over the configured word length
   function automatic logic par_error(input uart_lsr_pkg::byte_t d, input logic pbit,
                                      input logic [1:0] wlen, input logic en,
                                      input logic even, input logic stick);
      uart_lsr_pkg::byte_t mask;
      logic ones;
      logic expect_bit;
      mask = `MASK_ALL >> (`WLEN_MAX - wlen);
      ones = ^(d & mask);
      if (stick) begin
         expect_bit = ~even; // forced parity value
      end else begin
         expect_bit = even ? ones : ~ones;
      end
      par_error = en & (pbit != expect_bit);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   uart_lsr_pkg::byte_t cfg_reg; // software control
   logic fifo_err_reg; // sticky data error
   logic temt_reg; // holding and shift empty
   logic thre_reg; // holding stage empty
   logic break_armed_reg; // ready to accept a break char
   logic tx_valid_reg; // output stage holds a char
   uart_lsr_pkg::byte_t tx_data_reg; // output stage char
   logic irq_reg; // transmit interrupt
   uart_lsr_pkg::byte_t rd_data_reg; // read answer

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   wire sel_data = (addr_i == `REG_DATA);
   wire sel_cfg = (addr_i == `REG_CFG);
   wire sel_ls = (addr_i == `REG_LINE_STATUS);
   wire thr_write = wr_en_i & sel_data; // write to tx_holding_reg
   wire rhr_read = rd_en_i & sel_data; // read of rx_holding_reg
   wire cfg_write = wr_en_i & sel_cfg;
   wire fifo_mode = cfg_reg[`CFG_FIFO_EN];
   wire [`FIFO_CNT_W-1:0] cap = fifo_mode ? `CAP_FIFO : `CAP_NOFIFO;
   wire [`DATA_W-1:0] cfg_next = cfg_write ? wr_data_i : cfg_reg;

   ////////////////////////////////////////////////////////////////////////////
   // receive side: synchronised line, tagging, fifo
   logic line_high; // filtered serial input
   uart_lsr_pkg::rx_entry_t rx_head; // head entry
   uart_lsr_pkg::count_t rx_count; // fill level
   logic rx_full;
   logic rx_empty;

   lsr_line_sync u_line_sync (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .async_i(rx_line_i),
      .level_o(line_high)
   );

   // per-character error tags
   wire tag_par = par_error(rx_data_i, rx_par_bit_i, cfg_reg[`CFG_WLEN_HI:`CFG_WLEN_LO],
                            cfg_reg[`CFG_PAR_EN], cfg_reg[`CFG_PAR_EVEN],
                            cfg_reg[`CFG_PAR_STICK]);
   wire tag_frm = ~rx_stop_ok_i;
   wire tag_brk = rx_frame_zero_i;
   wire rx_dup_break = rx_frame_zero_i & ~break_armed_reg; // repeat of a held break
   wire rx_push = rx_char_valid_i & ~rx_full & ~rx_dup_break;
   wire rx_push_err = rx_push & (tag_par | tag_frm | tag_brk);
   wire rx_pop = rhr_read & ~rx_empty;
   wire [`RX_ENTRY_W-1:0] rx_entry = {tag_brk, tag_frm, tag_par, rx_data_i};

   lsr_char_fifo #(
      .WIDTH(`RX_ENTRY_W)
   ) u_rx_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .cap_i(cap),
      .push_i(rx_push),
      .push_data_i(rx_entry),
      .pop_i(rx_pop),
      .head_o(rx_head),
      .count_o(rx_count),
      .full_o(rx_full),
      .empty_o(rx_empty)
   );

   // head flags, zero when nothing is held
   wire head_brk = ~rx_empty & rx_head[`TAG_BRK];
   wire head_frm = ~rx_empty & rx_head[`TAG_FRM];
   wire head_par = ~rx_empty & rx_head[`TAG_PAR];
   wire fifo_err_next = rx_push_err | (fifo_err_reg & ~rhr_read);

   ////////////////////////////////////////////////////////////////////////////
   // transmit side: holding fifo plus one output stage
   uart_lsr_pkg::byte_t tx_head;
   uart_lsr_pkg::count_t tx_count;
   logic tx_full;
   logic tx_empty;

   wire tx_push = thr_write & ~tx_full;
   wire take_ok = tx_take_i & tx_valid_reg; // char moves into tx_shift_reg
   wire tx_load = ~tx_empty & (~tx_valid_reg | take_ok);
   wire tx_valid_next = tx_load | (tx_valid_reg & ~take_ok);
   wire [`FIFO_CNT_W-1:0] tx_count_after = tx_count + {4'h0, tx_push} - {4'h0, tx_load};
   wire thre_next = (tx_count_after == `CNT_ZERO) & ~tx_valid_next;
   wire temt_next = thre_next & ~take_ok & ~tx_shift_busy_i;
   wire irq_next = thre_next & cfg_next[`CFG_THRE_IE];

   lsr_char_fifo #(
      .WIDTH(`DATA_W)
   ) u_tx_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .cap_i(cap),
      .push_i(tx_push),
      .push_data_i(wr_data_i),
      .pop_i(tx_load),
      .head_o(tx_head),
      .count_o(tx_count),
      .full_o(tx_full),
      .empty_o(tx_empty)
   );

   ////////////////////////////////////////////////////////////////////////////
   // line status word and read mux
   wire [`DATA_W-1:0] line_status = {fifo_err_reg, temt_reg, thre_reg, head_brk, head_frm,
                                     head_par, `LS_LOW_ZERO};
   wire [`DATA_W-1:0] rd_next = sel_data ? rx_head[`DATA_W-1:0] :
                                sel_cfg ? cfg_reg :
                                sel_ls ? line_status : '0; // unmapped reads zero

   ////////////////////////////////////////////////////////////////////////////
   // config, line status writes are ignored
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cfg_reg <= `CFG_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // sticky data error and break arming
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         fifo_err_reg <= 1'b0;
         break_armed_reg <= 1'b1;
      end else begin
         fifo_err_reg <= fifo_err_next;
         if (rx_char_valid_i & rx_frame_zero_i) begin
            break_armed_reg <= 1'b0;
         end else if (line_high) begin
            break_armed_reg <= 1'b1; // line back to mark
         end
      end
   end

   // transmit flags and interrupt
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         thre_reg <= 1'b1;
         temt_reg <= 1'b1;
         irq_reg <= 1'b0;
      end else begin
         thre_reg <= thre_next;
         temt_reg <= temt_next;
         irq_reg <= irq_next;
      end
   end

   // transmit output stage
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         tx_valid_reg <= 1'b0;
         tx_data_reg <= '0;
      end else begin
         tx_valid_reg <= tx_valid_next;
         if (tx_load) begin
            tx_data_reg <= tx_head;
         end
      end
   end

   // read answer, one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rd_data_reg <= '0;
      end else if (rd_en_i) begin
         rd_data_reg <= rd_next;
      end
   end

   assign rd_data_o = rd_data_reg;
   assign tx_valid_o = tx_valid_reg;
   assign tx_data_o = tx_data_reg;
   assign tx_irq_o = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_err_push;
      rx_push_err;
   endsequence

   sequence s_err_held;
      fifo_err_reg ##1 fifo_err_reg;
   endsequence

   property p_fifo_err_set;
      @(posedge clk_i) disable iff (!resetn_i)
      s_err_push |=> s_err_held or (fifo_err_reg ##1 $past(rhr_read));
   endproperty
   a_fifo_err_set: assert property (p_fifo_err_set) else $error("data error flag not set");

   property p_fifo_err_clr;
      @(posedge clk_i) disable iff (!resetn_i)
      rhr_read && !rx_push_err |=> !fifo_err_reg;
   endproperty
   a_fifo_err_clr: assert property (p_fifo_err_clr) else $error("data error flag not cleared");

   property p_temt_set;
      @(posedge clk_i) disable iff (!resetn_i)
      tx_empty && !tx_valid_reg && !thr_write && !tx_shift_busy_i |=> temt_reg;
   endproperty
   a_temt_set: assert property (p_temt_set) else $error("transmit empty not set");

   property p_temt_clr;
      @(posedge clk_i) disable iff (!resetn_i)
      !tx_empty || tx_valid_reg || tx_shift_busy_i |=> !temt_reg;
   endproperty
   a_temt_clr: assert property (p_temt_clr) else $error("transmit empty set while occupied");

   property p_temt_fifo;
      @(posedge clk_i) disable iff (!resetn_i)
      fifo_mode && temt_reg |-> tx_empty && !tx_valid_reg && thre_reg;
   endproperty
   a_temt_fifo: assert property (p_temt_fifo) else $error("transmit empty with fifo data");

   sequence s_last_take;
      take_ok && tx_empty && !thr_write;
   endsequence

   property p_thre_on_take;
      @(posedge clk_i) disable iff (!resetn_i)
      s_last_take |=> thre_reg && !tx_valid_o;
   endproperty
   a_thre_on_take: assert property (p_thre_on_take) else $error("holding empty not set on move");

   property p_thre_clr;
      @(posedge clk_i) disable iff (!resetn_i)
      thr_write && !tx_full |=> !thre_reg ##1 !tx_empty || tx_valid_reg;
   endproperty
   a_thre_clr: assert property (p_thre_clr) else $error("holding empty not cleared on write");

   property p_irq;
      @(posedge clk_i) disable iff (!resetn_i)
      $rose(thre_reg) && cfg_reg[`CFG_THRE_IE] |-> tx_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("transmit interrupt missing");

   property p_dup_break;
      @(posedge clk_i) disable iff (!resetn_i)
      rx_char_valid_i && rx_frame_zero_i && !break_armed_reg |=> $stable(rx_count) || rx_count < $past(rx_count);
   endproperty
   a_dup_break: assert property (p_dup_break) else $error("second break character stored");

   property p_head_frame;
      @(posedge clk_i) disable iff (!resetn_i)
      rd_en_i && sel_ls && !rx_empty |=> rd_data_o[`LS_FRAME] == $past(rx_head[`TAG_FRM]);
   endproperty
   a_head_frame: assert property (p_head_frame) else $error("framing flag not from head");

endmodule

// ===== tx_shifter_model.sv
// transmit shift register model standing behind the holding stage
`timescale 1ns/1ps

module tx_shifter_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic stall_i,
   input wire logic [7:0] shift_len_i,
   input wire logic tx_valid_i,
   output logic take_o,
   output logic busy_o
);
   logic [7:0] left_reg; // cycles of shifting still to go

   ////////////////////////////////////////////////////////////////
   // load when stage full and shifter idle; busy from cycle after take
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         take_o <= 1'b0;
         busy_o <= 1'b0;
         left_reg <= 8'h00;
      end else begin
         take_o <= tx_valid_i & ~busy_o & ~take_o & ~stall_i;
         if (take_o) begin
            busy_o <= 1'b1;
            left_reg <= shift_len_i;
         end else if (busy_o) begin
            left_reg <= left_reg - 8'h01;
            busy_o <= (left_reg != 8'h01);
         end
      end
   end
endmodule

// ===== tb_uart_line_status_flags.sv
// self-checking bench for the line status flags block
`timescale 1ns/1ps
`include "uart_lsr_defs.svh"

module tb_uart_line_status_flags;
   logic clk_i, resetn_i, wr_en_i, rd_en_i, rx_valid, rx_par, rx_stop, rx_fz, rx_line;
   logic stall, take, busy, tx_valid_o, tx_irq_o;
   logic [2:0] addr_i;
   logic [7:0] wr_data_i, rx_data, shift_len, rd_data_o, tx_data_o, v, cfg;
   logic derr; // modelled data error flag
   int rxq[$]; // modelled receive entries
   int txq[$]; // bytes awaiting the shifter
   int n_mismatch, checks_done, cycles, i, k;
   logic [7:0] modes[6] = '{8'h0D, 8'h1D, 8'h3D, 8'h5D, 8'h7D, 8'h35};

   uart_line_status_flags u_uart_line_status_flags (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
      .rx_char_valid_i(rx_valid), .rx_data_i(rx_data), .rx_par_bit_i(rx_par), .rx_stop_ok_i(rx_stop),
      .rx_frame_zero_i(rx_fz), .rx_line_i(rx_line), .tx_take_i(take), .tx_shift_busy_i(busy),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_irq_o(tx_irq_o));
   tx_shifter_model u_tx_shifter_model (.clk_i(clk_i), .resetn_i(resetn_i), .stall_i(stall),
      .shift_len_i(shift_len), .tx_valid_i(tx_valid_o), .take_o(take), .busy_o(busy));

   ////////////////////////////////////////////////////////////////
   // clock, 5 ns period
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   // each byte leaving for the shifter must be the next one written
   always @(posedge clk_i)
      if (resetn_i && take && tx_valid_o)
         chk8(tx_data_o, 8'(txq.pop_front()));

   ////////////////////////////////////////////////////////////////
   // bus tasks: one-cycle strobes, read data in the following cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
      if (a == `REG_CFG) cfg = d;
      if (a == `REG_DATA) txq.push_back(d);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1 d = rd_data_o;
   endtask

   // parity error of a character under the current setting
   function automatic logic perr(logic [7:0] d, logic p);
      if (!cfg[4]) return 1'b0;
      if (cfg[6]) return p == cfg[5];
      return (^(d & (8'hFF >> (2'h3 - cfg[3:2]))) ^ p) == cfg[5];
   endfunction

   // one received character; model stores it only if accepted
   task automatic send(input logic [7:0] d, input logic p, input logic s, input logic fz, input logic acc);
      logic [2:0] t;
      @(posedge clk_i);
      {rx_valid, rx_data, rx_par, rx_stop, rx_fz} <= {1'b1, d, p, s, fz};
      @(posedge clk_i);
      rx_valid <= 1'b0;
      t = {fz, ~s, perr(d, p)};
      if (acc) rxq.push_back({t, d});
      if (acc && t != 3'h0) derr = 1'b1;
   endtask

   // line status against model; t gives transmitter-empty and holding-empty
   task automatic ls_chk(input logic [1:0] t);
      logic [2:0] h;
      h = (rxq.size() > 0) ? rxq[0][10:8] : 3'h0;
      rd(`REG_LINE_STATUS, v);
      chk8(v, {derr, t, h, `LS_LOW_ZERO});
   endtask

   task automatic pop_chk;
      rd(`REG_DATA, v);
      chk8(v, rxq[0][7:0]);
      void'(rxq.pop_front());
      derr = 1'b0;
   endtask

   task automatic wait_busy(input logic lvl);
      for (k = 0; k < 200 && busy !== lvl; k++) @(posedge clk_i);
   endtask

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {wr_en_i, rd_en_i, rx_valid, rx_par, rx_stop, rx_fz, derr} = '0;
      {addr_i, wr_data_i, rx_data, cfg} = '0;
      {rx_line, stall} = 2'b11;
      shift_len = 8'h14;
      resetn_i = 1'b0;
      void'($urandom(7));
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      ls_chk(2'b11);
      wr(`REG_LINE_STATUS, 8'hFF);
      ls_chk(2'b11);
      rd(3'h7, v);
      chk8(v, 8'h00);
      // single holding register, slow shifter, interrupt enabled
      wr(`REG_CFG, 8'h0E);
      rd(`REG_CFG, v);
      chk8(v, 8'h0E);
      wr(`REG_DATA, 8'($urandom()));
      ls_chk(2'b00);
      chk8({7'h0, tx_irq_o}, 8'h00);
      stall <= 1'b0;
      wait_busy(1'b1);
      ls_chk(2'b01);
      chk8({7'h0, tx_irq_o}, 8'h01);
      wait_busy(1'b0);
      ls_chk(2'b11);
      // single receive slot: second character is dropped
      send(8'h5A, 1'b0, 1'b1, 1'b0, 1'b1);
      send(8'hA5, 1'b0, 1'b0, 1'b0, 1'b0);
      pop_chk();
      ls_chk(2'b11);
      // fifo mode, prompt shifter, interrupt masked
      stall <= 1'b1;
      shift_len <= 8'h03;
      wr(`REG_CFG, 8'h0D);
      for (i = 0; i < 3; i++) wr(`REG_DATA, 8'($urandom()));
      ls_chk(2'b00);
      stall <= 1'b0;
      for (i = 0; i < 300 && txq.size() > 0; i++) @(posedge clk_i);
      wait_busy(1'b1); // last character enters the shifter
      wait_busy(1'b0);
      ls_chk(2'b11);
      chk8({7'h0, tx_irq_o}, 8'h00);
      // receive tags under every parity setting
      for (i = 0; i < 6; i++) begin
         wr(`REG_CFG, modes[i]);
         for (k = 0; k < 4; k++) send(8'($urandom()), 1'($urandom()), 1'($urandom()), 1'b0, 1'b1);
         for (k = 0; k < 4; k++) begin
            ls_chk(2'b11);
            pop_chk();
         end
         ls_chk(2'b11);
      end
      // break held low, then released and repeated
      wr(`REG_CFG, 8'h0D);
      rx_line <= 1'b0;
      repeat (6) @(posedge clk_i); // line low a whole frame before the break
      send(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
      send(8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
      rx_line <= 1'b1;
      repeat (6) @(posedge clk_i);
      rx_line <= 1'b0;
      repeat (6) @(posedge clk_i); // line low a whole frame before the break
      send(8'h00, 1'b0, 1'b0, 1'b1, 1'b1);
      ls_chk(2'b11);
      pop_chk();
      ls_chk(2'b11);
      pop_chk();
      ls_chk(2'b11);
      complete_run();
   end
endmodule
